// file: include/spe_pkg.sv
/*
  shared constants and types for the serial programming entry block.
  assumes nothing beyond a systemverilog compiler; compiled first.
*/
package spe_pkg;

  // key length and the fixed entry key (value is arbitrary)
  localparam int          KEY_BITS    = 32;
  localparam logic [KEY_BITS-1:0] KEY_DEFAULT = 32'h5a3c_96e1;

  // synchroniser lane count and lane positions in the shared sync vector
  localparam int          SYNC_LANES  = 5;
  localparam int          LANE_HV     = 0;   // high-voltage detector on master clear
  localparam int          LANE_MASTER_CLEAR = 1;   // master clear logic level, active low
  localparam int          LANE_CLK    = 2;   // programming clock as a plain level
  localparam int          LANE_DAT    = 3;   // programming data pin level
  localparam int          LANE_KEY    = 4;   // key-match toggle from the link domain

  // reset values
  localparam logic [4:0]  SYNC_RST    = 5'h02;  // master clear idles high
  localparam logic        BIT_RST     = 1'h0;

  // session states
  typedef enum logic [1:0] {
    SPE_NORMAL = 2'b00,   // normal operation
    SPE_HV     = 2'b01,   // session entered by high voltage
    SPE_LV     = 2'b10    // session entered by key
  } spe_state_t;

endpackage

// file: include/spe_key_if.sv
/*
  carrier between the link-domain key shifter and the system-domain entry logic.
  assumes the receiving side synchronises key_event_tgl before use.
*/
interface spe_key_if;
  logic key_event_tgl;   // flips once per matched key, link clock domain

  modport link (output key_event_tgl);
  modport sys  (input  key_event_tgl);
endinterface

// file: design/spe_key_shift.sv
/*
  link-domain key shifter: samples the data pin on each programming clock
  rising edge, compares the last 32 bits against the fixed key.
  assumes the programming clock may stop between frames; RESET is crossed in.
*/
module spe_key_shift #(
  parameter logic [spe_pkg::KEY_BITS-1:0] KEY = spe_pkg::KEY_DEFAULT
) (
  // link clock and pin
  input  wire logic link_clk,
  input  wire logic ser_data_in,
  // system reset, crossed into this domain
  input  wire logic reset,
  // toward the entry logic
  spe_key_if.link   kif
);

  logic [1:0]                     rst_sync_ff;  // reset synchroniser
  logic [spe_pkg::KEY_BITS-1:0]   window_ff;    // last key bits, newest in bit 0
  logic                           tgl_ff;       // key match event toggle
  logic [spe_pkg::KEY_BITS-1:0]   nxt_window;
  wire                            link_rst;
  wire                            key_hit;

  assign link_rst = rst_sync_ff[1];
  // shift in msb first, the new bit lands in bit 0
  assign nxt_window = {window_ff[spe_pkg::KEY_BITS-2:0], ser_data_in};
  assign key_hit    = (nxt_window == KEY);
  assign kif.key_event_tgl = tgl_ff;

  // reset crossing; only the second stage is read
  always_ff @(posedge link_clk) begin
    rst_sync_ff <= {rst_sync_ff[0], reset};
  end

  // shifter; a hit empties the window so a stale match never fires twice
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      window_ff <= '0;
      tgl_ff    <= spe_pkg::BIT_RST;
    end else if (key_hit) begin
      window_ff <= '0;
      tgl_ff    <= ~tgl_ff;
    end else begin
      window_ff <= nxt_window;
    end
  end

  chk_key_match_toggle : assert property (
    @(posedge link_clk) disable iff (link_rst)
    key_hit |=> (tgl_ff != $past(tgl_ff)) && (window_ff == '0)
  ) else $error("key match did not toggle event");

endmodule // spe_key_shift

// file: design/spe_entry_top.sv
/*
  serial programming entry logic: decides between normal operation, a
  high-voltage session and a key-entered low-voltage session, and gates the
  shared data pin for the command engine.
  assumes the pins arrive asynchronously and the programming clock is the
  link clock; the command engine and config bits run on SYS_CLK.
*/
// Operation
// - data pin two-way; clock pin is input
// - session lets engine read and write memory
// - key entry only when enable bit is one
// - enable bit zero disables key entry completely
// - key session lasts only while master clear low
// - enable bit one forces master clear reset on
// - enable bit cleared only in high-voltage session
module spe_entry_top (
  // system clock and reset
  input  wire logic SYS_CLK,
  input  wire logic RESET,
  // programming link pins
  input  wire logic PROG_SERIAL_CLOCK,
  input  wire logic PROG_SERIAL_DATA_I,
  output logic      PROG_SERIAL_DATA_O,
  output logic      PROG_SERIAL_DATA_OE,
  input  wire logic MASTER_CLEAR_PIN_N,
  input  wire logic PROG_HIGH_VOLTAGE_LEVEL,
  // configuration
  input  wire logic LOW_VOLTAGE_ENTRY_ENABLE,
  input  wire logic MASTER_CLEAR_RESET_CFG,
  output logic      MASTER_CLEAR_RESET_ENABLE,
  // command engine side
  input  wire logic ENG_TX_BIT,
  input  wire logic ENG_TX_DRIVE,
  input  wire logic ENG_LV_EN_CLEAR_REQ,
  output logic      LV_EN_CLEAR_GRANT,
  output logic      SER_BIT,
  output logic      SER_BIT_VALID,
  // session status
  output logic      PROG_MODE,
  output logic      HV_SESSION,
  output logic      LV_SESSION
);

  // link-domain key shifter
  spe_key_if kif ();

  spe_key_shift u_key (
    .link_clk    (PROG_SERIAL_CLOCK),
    .ser_data_in (PROG_SERIAL_DATA_I),
    .reset       (RESET),
    .kif         (kif.link)
  );

  // synchronisers: stage one feeds stage two only
  logic [spe_pkg::SYNC_LANES-1:0] sync1_ff;
  logic [spe_pkg::SYNC_LANES-1:0] sync2_ff;
  logic                           hv_d_ff;     // previous high-voltage level
  logic                           clk_d_ff;    // previous clock level
  logic                           key_d_ff;    // previous key toggle

  wire hv_s    = sync2_ff[spe_pkg::LANE_HV];
  wire master_clear_n = sync2_ff[spe_pkg::LANE_MASTER_CLEAR];
  wire clk_s   = sync2_ff[spe_pkg::LANE_CLK];
  wire dat_s   = sync2_ff[spe_pkg::LANE_DAT];
  wire key_s   = sync2_ff[spe_pkg::LANE_KEY];

  // edge decode on synchronised levels
  wire hv_rise   = hv_s & ~hv_d_ff;
  wire clk_rise  = clk_s & ~clk_d_ff;
  wire key_event = key_s ^ key_d_ff;

  // cross all pin levels and the key toggle
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      sync1_ff <= spe_pkg::SYNC_RST;
      sync2_ff <= spe_pkg::SYNC_RST;
    end else begin
      sync1_ff <= {kif.key_event_tgl, PROG_SERIAL_DATA_I, PROG_SERIAL_CLOCK,
                   MASTER_CLEAR_PIN_N, PROG_HIGH_VOLTAGE_LEVEL};
      sync2_ff <= sync1_ff;
    end
  end

  // history for edge detection
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      hv_d_ff  <= spe_pkg::BIT_RST;
      clk_d_ff <= spe_pkg::BIT_RST;
      key_d_ff <= spe_pkg::BIT_RST;
    end else begin
      hv_d_ff  <= hv_s;
      clk_d_ff <= clk_s;
      key_d_ff <= key_s;
    end
  end

  // session state
  spe_pkg::spe_state_t state_ff;   // current session
  spe_pkg::spe_state_t nxt_state;  // next session

  // entry conditions, named for the checks below
  wire lv_en_cfg  = LOW_VOLTAGE_ENTRY_ENABLE;
  wire hv_entry   = hv_rise & ~clk_s & ~dat_s;
  wire lv_entry   = key_event & lv_en_cfg & ~master_clear_n;
  wire in_session = (state_ff != spe_pkg::SPE_NORMAL);

  // next session; high voltage wins over a key arriving at once
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      spe_pkg::SPE_NORMAL: begin
        if (hv_entry) begin
          nxt_state = spe_pkg::SPE_HV;
        end else if (lv_entry) begin
          nxt_state = spe_pkg::SPE_LV;
        end
      end
      spe_pkg::SPE_HV: begin
        // session ends when the high voltage goes away
        if (!hv_s) begin
          nxt_state = spe_pkg::SPE_NORMAL;
        end
      end
      spe_pkg::SPE_LV: begin
        // leaving master clear low ends the key session
        if (master_clear_n) begin
          nxt_state = spe_pkg::SPE_NORMAL;
        end
      end
      default: begin
        nxt_state = spe_pkg::SPE_NORMAL;  // unused code recovers
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_ff <= spe_pkg::SPE_NORMAL;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs, all registered; pin drive only inside a session
  wire nxt_oe      = ENG_TX_DRIVE & in_session;
  wire nxt_grant   = ENG_LV_EN_CLEAR_REQ & (state_ff == spe_pkg::SPE_HV);
  wire nxt_rst_en  = lv_en_cfg | MASTER_CLEAR_RESET_CFG;
  // session flags decoded from the next state so they land with state_ff
  wire nxt_mode    = (nxt_state != spe_pkg::SPE_NORMAL);
  wire nxt_hv_ses  = (nxt_state == spe_pkg::SPE_HV);
  wire nxt_lv_ses  = (nxt_state == spe_pkg::SPE_LV);
  wire nxt_bit_vld = clk_rise & in_session;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      PROG_SERIAL_DATA_O  <= spe_pkg::BIT_RST;
      PROG_SERIAL_DATA_OE <= spe_pkg::BIT_RST;
      LV_EN_CLEAR_GRANT   <= spe_pkg::BIT_RST;
      MASTER_CLEAR_RESET_ENABLE <= spe_pkg::BIT_RST;
      SER_BIT             <= spe_pkg::BIT_RST;
      SER_BIT_VALID       <= spe_pkg::BIT_RST;
    end else begin
      PROG_SERIAL_DATA_O  <= ENG_TX_BIT & nxt_oe;
      PROG_SERIAL_DATA_OE <= nxt_oe;
      LV_EN_CLEAR_GRANT   <= nxt_grant;
      MASTER_CLEAR_RESET_ENABLE <= nxt_rst_en;
      SER_BIT             <= dat_s;
      SER_BIT_VALID       <= nxt_bit_vld;
    end
  end

  // session flags are flops of their own, loaded alongside state_ff,
  // so the pins never glitch on a state decode
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      PROG_MODE  <= spe_pkg::BIT_RST;
      HV_SESSION <= spe_pkg::BIT_RST;
      LV_SESSION <= spe_pkg::BIT_RST;
    end else begin
      PROG_MODE  <= nxt_mode;
      HV_SESSION <= nxt_hv_ses;
      LV_SESSION <= nxt_lv_ses;
    end
  end

  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  sequence quiet_hv_rise;
    (state_ff == spe_pkg::SPE_NORMAL) ##0 hv_rise ##0 (!clk_s && !dat_s);
  endsequence

  sequence key_in_reset_low;
    (state_ff == spe_pkg::SPE_NORMAL) ##0 key_event ##0
      (lv_en_cfg && !master_clear_n && !hv_entry);
  endsequence

  chk_drive_in_session : assert property (
    PROG_SERIAL_DATA_OE |-> $past(in_session) && $past(ENG_TX_DRIVE)
  ) else $error("data pin driven outside a session");

  chk_bit_pass_through : assert property (
    (in_session && clk_rise) |=> SER_BIT_VALID && (SER_BIT == $past(dat_s))
  ) else $error("received bit not offered to engine");

  chk_hv_entry_seq : assert property (
    quiet_hv_rise |=> HV_SESSION ##1 (HV_SESSION || !$past(hv_s))
  ) else $error("quiet high-voltage rise did not enter");

  chk_lv_needs_enable : assert property (
    $rose(LV_SESSION) |-> $past(lv_en_cfg) && !$past(master_clear_n)
  ) else $error("key session entered without enable");

  chk_lv_path_off : assert property (
    (!lv_en_cfg && !LV_SESSION) |=> !LV_SESSION
  ) else $error("key session entered while disabled");

  chk_lv_hold_low : assert property (
    (LV_SESSION && master_clear_n) |=> !PROG_MODE [*2]
  ) else $error("key session outlived master clear release");

  chk_reset_forced_on : assert property (
    lv_en_cfg |=> MASTER_CLEAR_RESET_ENABLE
  ) else $error("master clear reset not forced on");

  chk_clear_hv_only : assert property (
    LV_EN_CLEAR_GRANT |-> $past(HV_SESSION) && $past(ENG_LV_EN_CLEAR_REQ)
  ) else $error("enable clear granted outside high-voltage session");

  chk_key_enters : assert property (
    key_in_reset_low |=> LV_SESSION
  ) else $error("matched key did not enter");

endmodule // spe_entry_top

// file: bench/spe_prog_model.sv
/*
  behavioural model of the external programmer: drives the programming
  clock, the data pin and the master clear / high voltage levels.
  assumes the bench resolves the shared data wire from both enables.
*/
module spe_prog_model (
  // pins toward the device
  output logic sclk,
  output logic sdat,
  output logic sdat_oe,
  output logic master_clear_n,
  output logic hv
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle: clock stands still, master clear high, data driven low
  initial begin
    sclk    = 1'h0;
    sdat    = 1'h0;
    sdat_oe = 1'h1;
    master_clear_n = 1'h1;
    hv      = 1'h0;
  end

  // one 12 ns link clock period per bit, data set while the clock is low
  task automatic pulse(input logic b);
    sdat = b;
    #6 sclk = 1'h1;
    #6 sclk = 1'h0;
  endtask

  // key msb first; master clear dropped before the first clock
  task automatic send_key(input logic [31:0] k);
    master_clear_n = 1'h0;
    #20;
    for (int i = 31; i >= 0; i--) begin
      pulse(k[i]);
    end
    sdat = 1'h0;
  endtask

  // d = 1 breaks the low-data precondition on purpose
  task automatic hv_on(input logic d);
    sclk = 1'h0;
    sdat = d;
    #20 hv = 1'h1;
  endtask

  // master clear, high voltage and data drive in one go
  task automatic set_pins(input logic m, input logic h, input logic oe);
    master_clear_n = m;
    hv      = h;
    sdat_oe = oe;
  endtask
endmodule // spe_prog_model

// file: bench/spe_entry_top_bench.sv
/*
  self-checking bench for the entry logic: high-voltage and key entries,
  refusals, engine drive and clear grant.
  assumes the programmer model and the design with its default key.
*/
module spe_entry_top_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic      clk, rst, lv_en, cfg, tx_bit, tx_drv, clr_req, idle_tgl;
  wire logic sclk, m_d, m_oe, mclear_n, hv, dat_w;
  logic      d_o, d_oe, rst_en, grant, ser_bit, ser_v, pmode, hv_s, lv_s;
  int        miscompares, compares, cycles;

  // undriven wire toggles so a stale level never looks valid
  assign dat_w = d_oe ? d_o : (m_oe ? m_d : idle_tgl);

  spe_prog_model prog (.sclk(sclk), .sdat(m_d), .sdat_oe(m_oe), .master_clear_n(mclear_n),
    .hv(hv));

  spe_entry_top dut (
    .SYS_CLK(clk), .RESET(rst), .PROG_SERIAL_CLOCK(sclk), .PROG_SERIAL_DATA_I(dat_w),
    .PROG_SERIAL_DATA_O(d_o), .PROG_SERIAL_DATA_OE(d_oe), .MASTER_CLEAR_PIN_N(mclear_n),
    .PROG_HIGH_VOLTAGE_LEVEL(hv), .LOW_VOLTAGE_ENTRY_ENABLE(lv_en),
    .MASTER_CLEAR_RESET_CFG(cfg), .MASTER_CLEAR_RESET_ENABLE(rst_en), .ENG_TX_BIT(tx_bit),
    .ENG_TX_DRIVE(tx_drv), .ENG_LV_EN_CLEAR_REQ(clr_req), .LV_EN_CLEAR_GRANT(grant),
    .SER_BIT(ser_bit), .SER_BIT_VALID(ser_v), .PROG_MODE(pmode), .HV_SESSION(hv_s),
    .LV_SESSION(lv_s));

  // 4 ns system clock
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // cycle ceiling well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles   <= cycles + 1;
    idle_tgl <= ~idle_tgl;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("miscompares %0d compares %0d", miscompares, compares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  // n edges, then sample once updates have landed
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_mode(input logic exp);
    for (int i = 0; i < 12 && pmode !== exp; i++) step(1);
  endtask

  task automatic lv_try(input logic en, input logic [31:0] k);
    @(posedge clk) lv_en <= en;
    prog.send_key(k);
    wait_mode(1'h1);
  endtask

  task automatic t_reset;
    check(pmode, 1'h0, "mode after reset");
    check(d_oe, 1'h0, "data drive after reset");
    check(rst_en, 1'h0, "reset enable after reset");
    // outside a session the engine may neither drive nor clear
    @(posedge clk) cfg <= 1'h1;
    tx_drv  <= 1'h1;
    clr_req <= 1'h1;
    step(2);
    check(rst_en, 1'h1, "reset enable not set by cfg");
    check(d_oe, 1'h0, "data driven outside session");
    check(grant, 1'h0, "clear granted outside session");
    @(posedge clk) cfg <= 1'h0;
    tx_drv  <= 1'h0;
    clr_req <= 1'h0;
    step(2);
    check(rst_en, 1'h0, "reset enable stuck on");
  endtask

  task automatic t_hv;
    prog.hv_on(1'h0);
    wait_mode(1'h1);
    check(hv_s, 1'h1, "no hv session");
    check(lv_s, 1'h0, "lv flag in hv session");
    fork prog.pulse(1'h1); join_none
    for (int i = 0; i < 12 && ser_v !== 1'h1; i++) step(1);
    check(ser_v, 1'h1, "no bit valid");
    check(ser_bit, 1'h1, "bit value");
    prog.set_pins(1'h1, 1'h1, 1'h0);
    @(posedge clk) tx_drv <= 1'h1;
    tx_bit  <= 1'h1;
    clr_req <= 1'h1;
    step(1);
    check(d_oe, 1'h1, "no data drive");
    check(dat_w, 1'h1, "driven bit");
    check(grant, 1'h1, "no clear grant");
    @(posedge clk) tx_bit <= 1'h0;
    step(1);
    check(dat_w, 1'h0, "driven bit low");
    check(d_oe, 1'h1, "data drive dropped early");
    @(posedge clk) tx_drv <= 1'h0;
    clr_req <= 1'h0;
    // programmer takes the pin back only once the device has let go
    step(1);
    check(d_oe, 1'h0, "data drive not released");
    prog.set_pins(1'h1, 1'h0, 1'h1);
    wait_mode(1'h0);
    check(hv_s, 1'h0, "hv session held");
  endtask

  // data high while voltage rises must be refused
  task automatic t_hv_refused;
    prog.hv_on(1'h1);
    step(10);
    check(pmode, 1'h0, "entry with data high");
    prog.set_pins(1'h1, 1'h0, 1'h1);
    step(4);
  endtask

  task automatic t_lv_off;
    lv_try(1'h0, spe_pkg::KEY_DEFAULT);
    check(pmode, 1'h0, "key entry while disabled");
    prog.set_pins(1'h1, 1'h0, 1'h1);
    step(4);
  endtask

  task automatic t_lv_wrong;
    lv_try(1'h1, spe_pkg::KEY_DEFAULT ^ 32'h0000_0001);
    check(pmode, 1'h0, "entry on wrong key");
    check(rst_en, 1'h1, "reset not forced on");
    prog.set_pins(1'h1, 1'h0, 1'h1);
    step(4);
  endtask

  task automatic t_lv;
    lv_try(1'h1, spe_pkg::KEY_DEFAULT);
    check(lv_s, 1'h1, "no lv session");
    check(hv_s, 1'h0, "hv flag in lv session");
    @(posedge clk) clr_req <= 1'h1;
    step(8);
    check(grant, 1'h0, "clear granted in lv");
    check(lv_s, 1'h1, "lv session dropped");
    @(posedge clk) clr_req <= 1'h0;
    prog.set_pins(1'h1, 1'h0, 1'h1);
    wait_mode(1'h0);
    check(lv_s, 1'h0, "lv session held");
  endtask

  // reset outlasts 9 cycles so the link side sees three clock edges
  initial begin
    rst         = 1'h1;
    lv_en       = 1'h0;
    cfg         = 1'h0;
    tx_bit      = 1'h0;
    tx_drv      = 1'h0;
    clr_req     = 1'h0;
    idle_tgl    = 1'h0;
    miscompares = 0;
    compares    = 0;
    cycles      = 0;
    repeat (3) prog.pulse(1'h0);
    @(posedge clk) rst <= 1'h0;
    step(3);
    t_reset();
    t_hv();
    t_hv_refused();
    t_lv_off();
    t_lv_wrong();
    t_lv();
    stop_test();
  end
endmodule // spe_entry_top_bench
